// ---- src/sacc_pkg.sv ----
// Constants for the successive-approximation conversion control block
package sacc_pkg;
    // ==========================================================
    // Sizes
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned STEP_COUNT   = 8;
    localparam int unsigned SHIFT_W      = STEP_COUNT + 1;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned CONV_CLOCKS  = 64;
    // Internal phases run at half the external rate, so one step spans
    // several phase periods of two external clocks each
    localparam int unsigned PHASE_DIV    = 2;
    localparam int unsigned STEP_CLOCKS  = CONV_CLOCKS / STEP_COUNT;
    localparam int unsigned PHASES_STEP  = STEP_CLOCKS / PHASE_DIV;
    localparam int unsigned SET_HOLD_CLK = 8;
    localparam int unsigned PHASE_W      = 3;
    localparam int unsigned HOLD_W       = 4;
    localparam logic [PHASE_W-1:0] PHASE_LAST =
        PHASE_W'(STEP_CLOCKS - 1);
    localparam logic [HOLD_W-1:0]  HOLD_LOAD  = HOLD_W'(SET_HOLD_CLK);
    // ==========================================================
    // Codes and reset values
    localparam logic [DATA_W-1:0]  FULL_SCALE = 8'hFF;
    localparam logic [DATA_W-1:0]  ZERO_CODE  = 8'h00;
    localparam logic [SHIFT_W-1:0] SHIFT_RST  = 9'h000;
    localparam logic [SHIFT_W-1:0] SHIFT_INJ  = 9'h001;
    localparam logic [PHASE_W-1:0] PHASE_RST  = 3'h0;
    localparam logic [HOLD_W-1:0]  HOLD_RST   = 4'h0;
    localparam logic [DATA_W-1:0]  TRIAL_RST  = 8'h80;
endpackage

// ---- src/sacc_conversion_control.sv ----
// Conversion sequencing, approximation search, result latch and done flag
`timescale 1ns/1ps

// Behaviour
// - Search MSB first, eight comparisons spread over sixty-four clocks.
// - Load straight binary result into output latch, then drop done flag.
// - A new start aborts any running conversion and restarts sequencing.
// - Done output wired to start input with select low gives free running.
// - Falling start strobe clears approximation register and shift register.
// - Held reset while select and start low; begin 1 to 8 clocks after.
// - Select and start low set start flop, clearing shifter and done flop.
// - Start flop clears only at phase tick once set condition is gone.
// - Token leaving the shift register moves the result into output latch.
// - End detect sets done flop; done pin shows its inverse.
// - Internal phases run at half the external clock rate.
// - Done flop set drive stays active eight external clocks.
// - Set overrides a read clear that is held low continuously.
// - In free running, done low restarts and ends the done pulse quickly.
// - Select and read low clear done flop and drive all eight data bits.
// - Select, read and start strobe inputs are active low.
module sacc_conversion_control (
    input  wire logic                       CLK_SYS,
    input  wire logic                       RESET,
    input  wire logic                       CS_N,
    input  wire logic                       RD_N,
    input  wire logic                       WR_N,
    input  wire logic                       COMP_IN,
    output logic [sacc_pkg::DATA_W-1:0]     TRIAL_CODE,
    output logic [sacc_pkg::DATA_W-1:0]     DATA_OUT,
    output logic                            DATA_OE,
    output logic                            CONVERSION_DONE_N,
    output logic                            BUSY
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [sacc_pkg::PHASE_W-1:0] phase;
        logic                         clk_phase;
        logic                         wr_n_prev;
        logic                         start;
        logic                         shift_entry_flop;
        logic [sacc_pkg::SHIFT_W-1:0] shifter;
        logic [sacc_pkg::DATA_W-1:0]  approximation_register;
        logic [sacc_pkg::DATA_W-1:0]  out_latch;
        logic [sacc_pkg::DATA_W-1:0]  trial;
        logic [sacc_pkg::HOLD_W-1:0]  set_hold;
        logic                         done;
        logic                         busy;
    } sacc_state_t;

    sacc_state_t st_q;
    sacc_state_t st_d;

    // ==========================================================
    // Per-bit decision
    logic [sacc_pkg::DATA_W-1:0] bit_test;
    logic [sacc_pkg::DATA_W-1:0] search_next;
    logic [sacc_pkg::DATA_W-1:0] trial_next;
    logic [sacc_pkg::SHIFT_W-1:0] shift_next;

    // Shifter position i tests bit DATA_W-1-i, so the MSB goes first
    genvar gi;
    generate
        for (gi = 0; gi < sacc_pkg::DATA_W; gi++) begin : g_bit
            assign bit_test[sacc_pkg::DATA_W-1-gi] = st_q.shifter[gi];
            assign search_next[sacc_pkg::DATA_W-1-gi] =
                st_q.shifter[gi] ? COMP_IN
                                 : st_q.approximation_register[sacc_pkg::DATA_W-1-gi];
            assign trial_next[sacc_pkg::DATA_W-1-gi] =
                shift_next[gi] | search_next[sacc_pkg::DATA_W-1-gi];
        end
    endgenerate

    // ==========================================================
    // Sequencing
    logic set_cond;
    logic read_cond;
    logic step_tick;
    logic wr_fall;
    logic start_release;

    always_comb begin
        set_cond      = ~CS_N & ~WR_N;
        read_cond     = ~CS_N & ~RD_N;
        step_tick     = st_q.clk_phase & (st_q.phase == sacc_pkg::PHASE_LAST);
        wr_fall       = st_q.wr_n_prev & ~WR_N;
        start_release = st_q.start & step_tick & st_q.shift_entry_flop & ~set_cond;
        if (start_release) begin
            shift_next = sacc_pkg::SHIFT_INJ;
        end else if (step_tick && !st_q.shifter[sacc_pkg::SHIFT_W-1]) begin
            shift_next = {st_q.shifter[sacc_pkg::SHIFT_W-2:0], 1'b0};
        end else begin
            shift_next = st_q.shifter;
        end
    end

    always_comb begin
        st_d           = st_q;
        st_d.wr_n_prev = WR_N;
        // Free-running divider; the half-rate phase follows its low bit
        st_d.phase     = st_q.phase + 3'h1;
        st_d.clk_phase = ~st_q.clk_phase;

        // Start flop: set by level, cleared only on a phase tick
        if (set_cond) begin
            st_d.start = 1'b1;
        end else if (start_release) begin
            st_d.start = 1'b0;
        end

        // Entry flop takes the one offered by the start flop at once, so a
        // one-cycle strobe still begins on the first tick after it ends
        if (start_release) begin
            st_d.shift_entry_flop = 1'b0;
        end else if (st_q.start || set_cond) begin
            st_d.shift_entry_flop = 1'b1;
        end

        if (st_q.start || set_cond || wr_fall) begin
            // Held reset; a new start also aborts a running search
            st_d.shifter                = sacc_pkg::SHIFT_RST;
            st_d.approximation_register = sacc_pkg::ZERO_CODE;
            st_d.trial                  = sacc_pkg::TRIAL_RST;
            st_d.busy                   = st_q.start | set_cond;
            if (start_release) begin
                st_d.shifter = sacc_pkg::SHIFT_INJ;
                st_d.busy    = 1'b1;
            end
        end else if (st_q.shifter[sacc_pkg::SHIFT_W-1]) begin
            // Token out of the end: transfer the word, start the set drive
            st_d.out_latch = st_q.approximation_register;
            st_d.set_hold  = sacc_pkg::HOLD_LOAD;
            st_d.shifter   = sacc_pkg::SHIFT_RST;
            st_d.busy      = 1'b0;
        end else if (step_tick && (bit_test != sacc_pkg::ZERO_CODE)) begin
            st_d.approximation_register = search_next;
            st_d.shifter                = shift_next;
            st_d.trial                  = trial_next;
        end

        // Set drive counts external clocks; a restart withdraws it
        if (st_q.start || set_cond) begin
            st_d.set_hold = sacc_pkg::HOLD_RST;
        end else if (st_q.set_hold != sacc_pkg::HOLD_RST) begin
            st_d.set_hold = st_q.set_hold - 4'h1;
        end

        // Done flop: set beats the read clear, start clears it
        if (st_q.set_hold != sacc_pkg::HOLD_RST && !st_q.start) begin
            st_d.done = 1'b1;
        end else if (st_q.start || read_cond) begin
            st_d.done = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_q.phase                  <= sacc_pkg::PHASE_RST;
            st_q.clk_phase              <= 1'b0;
            st_q.wr_n_prev              <= 1'b1;
            st_q.start                  <= 1'b0;
            st_q.shift_entry_flop       <= 1'b0;
            st_q.shifter                <= sacc_pkg::SHIFT_RST;
            st_q.approximation_register <= sacc_pkg::ZERO_CODE;
            st_q.out_latch              <= sacc_pkg::ZERO_CODE;
            st_q.trial                  <= sacc_pkg::TRIAL_RST;
            st_q.set_hold               <= sacc_pkg::HOLD_RST;
            st_q.done                   <= 1'b0;
            st_q.busy                   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    // Enable is a plain gate of the strobes so the bus releases at once
    assign DATA_OE           = ~CS_N & ~RD_N;
    assign DATA_OUT          = st_q.out_latch;
    assign CONVERSION_DONE_N = ~st_q.done;
    assign TRIAL_CODE        = st_q.trial;
    assign BUSY              = st_q.busy;

endmodule

// ---- verification/sacc_conversion_control_asserts.sv ----
// Port-level assertion checker for the conversion control block
`timescale 1ns/1ps
module sacc_conv_checker (
    input wire logic                        CLK_SYS,
    input wire logic                        RESET,
    input wire logic                        CS_N,
    input wire logic                        RD_N,
    input wire logic                        WR_N,
    input wire logic                        COMP_IN,
    input wire logic [sacc_pkg::DATA_W-1:0] TRIAL_CODE,
    input wire logic [sacc_pkg::DATA_W-1:0] DATA_OUT,
    input wire logic                        DATA_OE,
    input wire logic                        CONVERSION_DONE_N,
    input wire logic                        BUSY
);
    // ==========================================================
    // Cycles since the last start request, saturating
    logic [6:0] cnt_q;
    logic       clr_req;
    assign clr_req = !CS_N && (!RD_N || !WR_N);
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) cnt_q <= 7'h7F;
        else if (!CS_N && !WR_N) cnt_q <= 7'h00;
        else if (cnt_q != 7'h7F) cnt_q <= cnt_q + 7'h01;
    end
    default clocking dck @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // ==========================================================
    a_oe_follows_pins: assert property (DATA_OE == (!CS_N && !RD_N))
        else $error("drive enable differs from select and read");
    a_start_clears: assert property ((!CS_N && !WR_N) |=>
        (BUSY && TRIAL_CODE == 8'h80) ##1 CONVERSION_DONE_N) else $error("start not taken");
    a_busy_min: assert property ((cnt_q > 7'h00 && cnt_q < 7'h42) |-> BUSY)
        else $error("conversion ended too soon");
    a_busy_bound: assert property (cnt_q == 7'h49 |-> !BUSY)
        else $error("conversion did not end in time");
    a_set_drive_held: assert property (($fell(CONVERSION_DONE_N) && WR_N) ##1 WR_N[*6]
        |-> !CONVERSION_DONE_N) else $error("done pulse too short");
    a_flag_after_end: assert property ($fell(CONVERSION_DONE_N) |-> !BUSY)
        else $error("done fell during conversion");
    a_flag_rise_cause: assert property ($rose(CONVERSION_DONE_N)
        |-> $past(clr_req) || $past(clr_req, 2)) else $error("done rose without cause");
    a_latch_at_end: assert property ($changed(DATA_OUT)
        |-> !BUSY && CONVERSION_DONE_N) else $error("result latch changed off transfer");
endmodule

bind sacc_conversion_control sacc_conv_checker sacc_conv_checker_inst (.CLK_SYS(CLK_SYS),
    .RESET(RESET), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .COMP_IN(COMP_IN),
    .TRIAL_CODE(TRIAL_CODE), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .CONVERSION_DONE_N(CONVERSION_DONE_N), .BUSY(BUSY));

// ---- verification/sacc_far_model.sv ----
// Comparator model standing behind the ladder code
`timescale 1ns/1ps
module sacc_far_model (
    input  wire logic [sacc_pkg::DATA_W-1:0] trial_code,
    input  wire logic [sacc_pkg::DATA_W-1:0] level,
    output logic                             comp
);
    // Keep the tested bit while the trial does not exceed the input level
    assign comp = (trial_code <= level);
endmodule

// ---- verification/test_sar_adc_conversion_control.sv ----
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
module test_sar_adc_conversion_control;
    logic        clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_drv = 1'b1, free = 1'b0;
    logic [7:0]  level = 8'h00, trial, dout;
    logic        comp, oe, done_n, busy, wr_n, prev_n;
    int          miscompares = 0, cmp_count = 0, n, falls, lows;
    logic [15:0] rows [6] = '{16'h0000, 16'hFFFF, 16'h8080, 16'h7F7F, 16'hA5A5, 16'h0101};
    always #12.5 clk = ~clk;
    // Free running loops the done flag back to the start strobe
    assign wr_n = free ? (done_n & wr_drv) : wr_drv;
    sacc_conversion_control sacc_conversion_control_inst (.CLK_SYS(clk), .RESET(rst),
        .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .COMP_IN(comp), .TRIAL_CODE(trial),
        .DATA_OUT(dout), .DATA_OE(oe), .CONVERSION_DONE_N(done_n), .BUSY(busy));
    sacc_far_model sacc_far_model_inst (.trial_code(trial), .level(level), .comp(comp));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic start(input int w);
        wr_drv = 1'b0;
        ticks(w);
        wr_drv = 1'b1;
        // Let an edge see the strobe high and the start clear the old flag
        ticks(1);
    endtask
    task automatic wait_done(input int lim);
        n = 0;
        while (done_n !== 1'b0 && n < lim) begin
            ticks(1);
            n++;
        end
        chk({7'h00, done_n}, 8'h00);
    endtask
    task automatic give_verdict;
        $display("miscompares %0d comparisons %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        ticks(13);
        rst = 1'b0;
        chk({busy, trial[6:0]}, 8'h00);
        chk({7'h00, done_n}, 8'h01);
        rd_n = 1'b0;
        ticks(1);
        chk({7'h00, oe}, 8'h00);
        rd_n = 1'b1;
        cs_n = 1'b0;
        start(1);
        wait_done(100);
        foreach (rows[i]) begin
            level = rows[i][15:8];
            start(1);
            wait_done(100);
            chk({7'h00, oe}, 8'h00);
            ticks(10);
            rd_n = 1'b0;
            ticks(1);
            chk(dout, rows[i][7:0]);
            chk({7'h00, oe}, 8'h01);
            rd_n = 1'b1;
            ticks(1);
            chk({7'h00, done_n}, 8'h01);
        end
        level = 8'h3C;
        start(1);
        ticks(30);
        level = 8'hC3;
        start(1);
        wait_done(100);
        rd_n = 1'b0;
        ticks(1);
        chk(dout, 8'hC3);
        rd_n = 1'b1;
        start(20);
        chk(trial, 8'h80);
        ticks(64);
        chk({7'h00, busy}, 8'h01);
        wait_done(9);
        rd_n = 1'b0;
        start(1);
        wait_done(100);
        ticks(6);
        chk({7'h00, done_n}, 8'h00);
        ticks(6);
        chk({7'h00, done_n}, 8'h01);
        rd_n = 1'b1;
        free = 1'b1;
        falls = 0;
        lows = 0;
        prev_n = 1'b1;
        start(1);
        repeat (300) begin
            ticks(1);
            if (done_n === 1'b0) lows++;
            if (done_n === 1'b0 && prev_n === 1'b1) falls++;
            prev_n = done_n;
        end
        // A pulse cut by the end of the window still has its second sample
        if (done_n === 1'b0) begin
            ticks(1);
            if (done_n === 1'b0) lows++;
        end
        chk({7'h00, falls >= 3}, 8'h01);
        chk(8'(lows), 8'(2 * falls));
        // Reset in mid-run: back to idle, and no restart until a new pulse
        rst = 1'b1;
        ticks(2);
        chk(trial, 8'h80);
        chk(dout, 8'h00);
        chk({busy, 6'h00, done_n}, 8'h01);
        rst = 1'b0;
        ticks(20);
        chk({7'h00, busy}, 8'h00);
        start(1);
        wait_done(100);
        give_verdict;
    end
    // Whole sequence needs about 1300 cycles; allow many times that
    initial begin
        #500000;
        miscompares++;
        give_verdict;
    end
endmodule
